// ---- sdahu_pkg.sv ----
// Summary of operation
// RULE_01: Truncating store converts stack top, then pops
// RULE_02: Store widths of 16, 32 and 64 bits
// RULE_03: Control word only unmasks invalid and inexact
// RULE_04: Aligned split-avoiding load fetches sixteen bytes
// RULE_05: Unaligned load fetches 32-byte block, extracts sixteen
// RULE_06: Odd duplicate writes elements 3,3,1,1
// RULE_07: Even duplicate writes elements 2,2,0,0
// RULE_08: Quadword duplicate fills both destination halves
// RULE_09: Single add-subtract: add odd, subtract even lanes
// RULE_10: Double add-subtract: upper adds, lower subtracts
// RULE_11: Single pairwise add of adjacent element pairs
// RULE_12: Single pairwise subtract, lower minus upper
// RULE_13: Double pairwise add: b1+b0, a1+a0
// RULE_14: Double pairwise subtract: b0-b1, a0-a1
// RULE_15: 64-bit mode extends vector register index
// RULE_16: Width bit selects 64-bit general registers
// RULE_17: Meaningless extension prefix ignored, never faults
// RULE_18: Compatibility mode behaves like protected mode
// RULE_19: SIMD control status governs rounding, masks, flags
// RULE_20: Address-watch arms range for write-back stores
// RULE_21: Wait sleeps until watched range is stored
// RULE_22: General input registers are never modified
// RULE_23: IEEE add per precision, raising SIMD flags
`timescale 1ns/1ps
`default_nettype none
package sdahu_pkg;
	localparam int RM_LSB = 13;
	localparam int MASK_LSB = 7;
	localparam int FL_IE = 0;
	localparam int FL_DE = 1;
	localparam int FL_OE = 3;
	localparam int FL_UE = 4;
	localparam int FL_PE = 5;
	localparam int FPCTL_IM = 0;
	localparam int FPCTL_PM = 5;
	localparam logic [1:0] RM_NEAR = 2'h0;
	localparam logic [1:0] RM_DOWN = 2'h1;
	localparam logic [1:0] RM_UP = 2'h2;
	localparam logic [1:0] IW_WORD = 2'h0;
	localparam logic [1:0] IW_DWORD = 2'h1;
	localparam logic [63:0] LIM_WORD = 64'h0000_0000_0000_7fff;
	localparam logic [63:0] LIM_DWORD = 64'h0000_0000_7fff_ffff;
	localparam logic [63:0] LIM_QWORD = 64'h7fff_ffff_ffff_ffff;
	localparam int DBL_BIAS = 1023;
	localparam int DBL_MW = 52;
	localparam logic [3:0] LD_OFF_MASK = 4'hf;
	localparam int MON_LINE_BYTES = 64;

	typedef enum logic [3:0] {
		OP_TRUNC_INT_STORE_POP,
		OP_SPLIT_AVOID_LOAD,
		OP_DUP_ODD,
		OP_DUP_EVEN,
		OP_DUP_QUAD,
		OP_ADDSUB_SINGLE,
		OP_ADDSUB_DOUBLE,
		OP_PAIR_ADD_SINGLE,
		OP_PAIR_SUB_SINGLE,
		OP_PAIR_ADD_DOUBLE,
		OP_PAIR_SUB_DOUBLE,
		OP_ADDR_WATCH,
		OP_WAIT_WATCHED_STORE
	} sdahu_op_e;

	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SLEEP} sdahu_st_e;

	typedef struct packed {
		sdahu_st_e st;
		logic [127:0] res;
		logic res_vld;
		logic [3:0] dst;
		logic [5:0] sflg;
		logic sexc;
		logic [63:0] ires;
		logic istore;
		logic [1:0] fstat;
		logic fexc;
		logic pop;
		logic ldreq;
		logic [63:0] ldaddr;
		logic ldwide;
		logic [3:0] off;
		logic armed;
		logic [63:0] base;
		logic done;
	} sdahu_state_s;
endpackage

module sdahu_fp_add
	import sdahu_pkg::*;
#(
	parameter int EW = 8,
	parameter int MW = 23
) (
	input wire logic [EW+MW:0] x_i,
	input wire logic [EW+MW:0] y_i,
	input wire logic sub_i,
	input wire logic [1:0] rm_i,
	output logic [EW+MW:0] z_o,
	output logic [5:0] flg_o
);
	localparam int NW = MW + 4;
	localparam logic [EW-1:0] EMAX = '1;
	if (EW < 2 || MW < 3)
	begin : g_bad
		$error("Format too narrow");
	end
	logic sx, sy, sl, ss, zs, inc, gx, nx, ny;
	logic [EW-1:0] ex, ey, el, es;
	logic [MW:0] mx, my, ml, ms;
	logic [2*NW-1:0] sh;
	logic [NW-1:0] sm;
	logic [NW:0] n;
	logic [MW+1:0] m;
	int d, e;
	always_comb
	begin
		sx = x_i[EW+MW];
		sy = y_i[EW+MW] ^ sub_i;
		ex = x_i[EW+MW-1:MW];
		ey = y_i[EW+MW-1:MW];
		mx = {ex != '0, x_i[MW-1:0]};
		my = {ey != '0, y_i[MW-1:0]};
		nx = ex == EMAX && x_i[MW-1:0] != '0;
		ny = ey == EMAX && y_i[MW-1:0] != '0;
		flg_o = '0;
		flg_o[FL_DE] = (ex == '0 && mx != '0) || (ey == '0 && my != '0);
		// Larger magnitude leads so the difference never goes negative
		gx = {ex, mx} >= {ey, my};
		sl = gx ? sx : sy;
		ss = gx ? sy : sx;
		el = gx ? ex : ey;
		es = gx ? ey : ex;
		ml = gx ? mx : my;
		ms = gx ? my : mx;
		e = (el == '0) ? 1 : int'(el);
		d = e - ((es == '0) ? 1 : int'(es));
		if (d > 2 * NW - 1)
			d = 2 * NW - 1;
		sh = {ms, 3'h0, {NW{1'b0}}} >> d;
		sm = {sh[2*NW-1:NW+1], sh[NW] | (|sh[NW-1:0])};
		if (sl == ss)
			n = {1'b0, ml, 3'h0} + {1'b0, sm};
		else
			n = {1'b0, ml, 3'h0} - {1'b0, sm};
		if (n[NW])
		begin
			n = {1'b0, n[NW:2], n[1] | n[0]};
			e = e + 1;
		end
		for (int i = 0; i < NW; i++)
		begin
			if (!n[NW-1] && e > 1)
			begin
				n = n << 1;
				e = e - 1;
			end
		end
		zs = sl;
		if (n == '0)
			zs = (sx == sy) ? sx : (rm_i == RM_DOWN);
		case (rm_i)
			RM_NEAR: inc = n[2] & (n[1] | n[0] | n[3]);
			RM_DOWN: inc = zs & (|n[2:0]);
			RM_UP: inc = !zs & (|n[2:0]);
			default: inc = 1'b0;
		endcase
		m = {1'b0, n[NW-1:3]} + {{(MW+1){1'b0}}, inc};
		if (m[MW+1])
		begin
			m = m >> 1;
			e = e + 1;
		end
		flg_o[FL_PE] = |n[2:0];
		flg_o[FL_UE] = !m[MW] && flg_o[FL_PE];
		z_o = {zs, m[MW] ? e[EW-1:0] : {EW{1'b0}}, m[MW-1:0]};
		if (e >= int'(EMAX))
		begin
			flg_o[FL_OE] = 1'b1;
			flg_o[FL_PE] = 1'b1;
			if (rm_i == RM_NEAR || rm_i == (zs ? RM_DOWN : RM_UP))
				z_o = {zs, EMAX, {MW{1'b0}}};
			else
				z_o = {zs, EMAX - 1'b1, {MW{1'b1}}};
		end
		if (nx || ny)
		begin
			flg_o = '0;
			flg_o[FL_IE] = (nx && !x_i[MW-1]) || (ny && !y_i[MW-1]);
			z_o = nx ? x_i : y_i;
			z_o[MW-1] = 1'b1;
		end
		else if (ex == EMAX || ey == EMAX)
		begin
			flg_o = '0;
			z_o = (ex == EMAX) ? {sx, EMAX, {MW{1'b0}}} : {sy, EMAX, {MW{1'b0}}};
			if (ex == EMAX && ey == EMAX && sx != sy)
			begin
				flg_o[FL_IE] = 1'b1;
				z_o = {1'b1, EMAX, 1'b1, {(MW-1){1'b0}}};
			end
		end
	end
endmodule // sdahu_fp_add
`default_nettype wire

// ---- sdahu_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdahu_unit
	import sdahu_pkg::*;
#(
	parameter int LINE_BYTES = MON_LINE_BYTES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic op_valid_i,
	input wire sdahu_op_e op_i,
	output logic op_ready_o,
	input wire logic [127:0] a_i,
	input wire logic [127:0] b_i,
	input wire logic [2:0] reg_idx_i,
	input wire logic mode64_i,
	input wire logic reg_extension_prefix_i,
	input wire logic reg_extension_index_bit_i,
	input wire logic reg_extension_width_bit_i,
	input wire logic [31:0] simd_fp_ctrl_status_i,
	input wire logic [15:0] fp_control_word_i,
	input wire logic [63:0] fp_stack_top_i,
	input wire logic [1:0] int_width_i,
	input wire logic [63:0] addr_i,
	input wire logic [63:0] gpr_addr_i,
	input wire logic [255:0] mem_data_i,
	input wire logic mem_valid_i,
	input wire logic store_valid_i,
	input wire logic store_wb_i,
	input wire logic [63:0] store_addr_i,
	output logic [127:0] res_o,
	output logic res_valid_o,
	output logic [3:0] res_dst_o,
	output logic [5:0] simd_flags_o,
	output logic simd_exc_o,
	output logic [63:0] int_res_o,
	output logic int_store_o,
	output logic [1:0] fp_status_o,
	output logic fp_exc_o,
	output logic fp_pop_o,
	output logic ld_req_o,
	output logic [63:0] ld_addr_o,
	output logic ld_wide_o,
	output logic sleep_o,
	output logic done_o
);
	if (LINE_BYTES < 16 || (LINE_BYTES & (LINE_BYTES - 1)) != 0)
	begin : g_bad
		$error("Watch line must be a power of two, at least 16");
	end

	localparam logic [63:0] LINE_MASK = ~(64'(LINE_BYTES) - 64'h1);

	sdahu_state_s r, nx;
	logic issue;
	logic hit;
	logic [1:0] rm;
	logic [5:0] smask;
	logic [127:0] sgl_z;
	logic [127:0] dbl_z;
	logic [5:0] sflg_l [4];
	logic [5:0] dflg_l [2];
	logic [5:0] sflg_s;
	logic [5:0] sflg_d;
	logic [63:0] mon_addr;
	logic [52:0] tm;
	logic [127:0] tt;
	logic [63:0] lim;
	logic [63:0] mag;
	logic [63:0] ti_val;
	logic ti_ie;
	logic ti_pe;
	logic ti_sign;
	int tsh;

	assign issue = op_valid_i && r.st == ST_IDLE;
	assign op_ready_o = r.st == ST_IDLE;
	// Core rounding and masks reach every packed lane
	assign rm = simd_fp_ctrl_status_i[RM_LSB+1:RM_LSB]; // [RULE_19]
	assign smask = simd_fp_ctrl_status_i[MASK_LSB+5:MASK_LSB]; // [RULE_19]
	assign hit = store_valid_i && store_wb_i && (store_addr_i & LINE_MASK) == r.base && r.armed;

	// Same adders serve add-subtract and pairwise forms; only operand and subtract-select steering differ
	for (genvar i = 0; i < 4; i++)
	begin : g_sgl
		logic [127:0] src;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] x;
		logic [31:0] y;
		logic sub;
		assign src = (i < 2) ? a_i : b_i;
		assign lo = src[64*(i%2) +: 32];
		assign hi = src[64*(i%2)+32 +: 32];
		always_comb
		begin
			x = a_i[32*i +: 32];
			y = b_i[32*i +: 32];
			sub = (i % 2) == 0; // [RULE_09]
			case (op_i)
				OP_PAIR_ADD_SINGLE:
				begin
					x = hi; // [RULE_11]
					y = lo;
					sub = 1'b0;
				end
				OP_PAIR_SUB_SINGLE:
				begin
					x = lo; // [RULE_12]
					y = hi;
					sub = 1'b1;
				end
				default:
				begin
					x = a_i[32*i +: 32];
				end
			endcase
		end
		sdahu_fp_add #(.EW(8), .MW(23)) u_add (
			.x_i(x),
			.y_i(y),
			.sub_i(sub),
			.rm_i(rm),
			.z_o(sgl_z[32*i +: 32]),
			.flg_o(sflg_l[i])
		); // [RULE_23]
	end

	for (genvar j = 0; j < 2; j++)
	begin : g_dbl
		logic [127:0] src;
		logic [63:0] x;
		logic [63:0] y;
		logic sub;
		assign src = (j == 0) ? a_i : b_i;
		always_comb
		begin
			x = a_i[64*j +: 64];
			y = b_i[64*j +: 64];
			sub = j == 0; // [RULE_10]
			case (op_i)
				OP_PAIR_ADD_DOUBLE:
				begin
					x = src[127:64]; // [RULE_13]
					y = src[63:0];
					sub = 1'b0;
				end
				OP_PAIR_SUB_DOUBLE:
				begin
					x = src[63:0]; // [RULE_14]
					y = src[127:64];
					sub = 1'b1;
				end
				default:
				begin
					x = a_i[64*j +: 64];
				end
			endcase
		end
		sdahu_fp_add #(.EW(11), .MW(52)) u_add (
			.x_i(x),
			.y_i(y),
			.sub_i(sub),
			.rm_i(rm),
			.z_o(dbl_z[64*j +: 64]),
			.flg_o(dflg_l[j])
		); // [RULE_23]
	end

	assign sflg_s = sflg_l[0] | sflg_l[1] | sflg_l[2] | sflg_l[3];
	assign sflg_d = dflg_l[0] | dflg_l[1];

	// Watch address width follows the width bit; prefix alone outside 64-bit mode is moot
	assign mon_addr = (mode64_i && reg_extension_prefix_i && reg_extension_width_bit_i)
		? gpr_addr_i : {32'h0, gpr_addr_i[31:0]}; // [RULE_16] [RULE_17]

	// Truncation ignores the rounding field entirely
	always_comb
	begin
		ti_sign = fp_stack_top_i[63];
		tm = {1'b1, fp_stack_top_i[DBL_MW-1:0]};
		tsh = int'(fp_stack_top_i[62:DBL_MW]) - DBL_BIAS;
		tt = '0;
		ti_ie = 1'b0;
		ti_pe = 1'b0;
		case (int_width_i)
			IW_WORD: lim = LIM_WORD; // [RULE_02]
			IW_DWORD: lim = LIM_DWORD;
			default: lim = LIM_QWORD;
		endcase
		if (fp_stack_top_i[62:DBL_MW] == '1)
			ti_ie = 1'b1;
		else if (tsh < 0)
			ti_pe = fp_stack_top_i[62:0] != '0;
		else if (tsh > 62)
			ti_ie = 1'b1;
		else
		begin
			tt = {75'h0, tm} << (tsh + 12); // [RULE_01]
			ti_pe = |tt[63:0];
		end
		mag = tt[127:64];
		if (mag > lim + {63'h0, ti_sign})
			ti_ie = 1'b1;
		if (ti_ie)
			ti_pe = 1'b0;
		// Out of range stores the integer indefinite of the chosen width
		ti_val = ti_ie ? ~lim : (ti_sign ? -mag : mag);
	end

	always_comb
	begin
		nx = r;
		nx.res_vld = 1'b0;
		nx.istore = 1'b0;
		nx.pop = 1'b0;
		nx.ldreq = 1'b0;
		nx.done = 1'b0;
		if (hit)
			nx.armed = 1'b0;
		case (r.st)
			ST_IDLE:
			begin
				if (op_valid_i)
				begin
					// Mode-dependent decoding only; compatibility mode runs the same path
					nx.dst = {mode64_i & reg_extension_prefix_i & reg_extension_index_bit_i,
						reg_idx_i}; // [RULE_15] [RULE_18]
					nx.done = 1'b1;
					nx.res_vld = 1'b1;
					case (op_i)
						OP_TRUNC_INT_STORE_POP:
						begin
							nx.res_vld = 1'b0;
							nx.ires = ti_val; // [RULE_01]
							nx.fstat = {ti_pe, ti_ie};
							nx.fexc = (ti_ie & !fp_control_word_i[FPCTL_IM])
								| (ti_pe & !fp_control_word_i[FPCTL_PM]); // [RULE_03]
							// An unmasked invalid faults before anything is stored or popped
							nx.istore = !(ti_ie && !fp_control_word_i[FPCTL_IM]);
							nx.pop = !(ti_ie && !fp_control_word_i[FPCTL_IM]); // [RULE_01]
						end
						OP_SPLIT_AVOID_LOAD:
						begin
							nx.res_vld = 1'b0;
							nx.done = 1'b0;
							nx.ldreq = 1'b1;
							nx.ldaddr = {addr_i[63:4], addr_i[3:0] & ~LD_OFF_MASK}; // [RULE_04]
							nx.ldwide = addr_i[3:0] != 4'h0; // [RULE_05]
							nx.off = addr_i[3:0];
							nx.st = ST_LOAD;
						end
						OP_DUP_ODD:
						begin
							nx.res = {{2{b_i[127:96]}}, {2{b_i[63:32]}}}; // [RULE_06]
						end
						OP_DUP_EVEN:
						begin
							nx.res = {{2{b_i[95:64]}}, {2{b_i[31:0]}}}; // [RULE_07]
						end
						OP_DUP_QUAD:
						begin
							nx.res = {2{b_i[63:0]}}; // [RULE_08]
						end
						OP_ADDSUB_SINGLE, OP_PAIR_ADD_SINGLE, OP_PAIR_SUB_SINGLE:
						begin
							nx.res = sgl_z; // [RULE_09] [RULE_11] [RULE_12]
							nx.sflg = sflg_s;
							nx.sexc = |(sflg_s & ~smask); // [RULE_19]
						end
						OP_ADDSUB_DOUBLE, OP_PAIR_ADD_DOUBLE, OP_PAIR_SUB_DOUBLE:
						begin
							nx.res = dbl_z; // [RULE_10] [RULE_13] [RULE_14]
							nx.sflg = sflg_d;
							nx.sexc = |(sflg_d & ~smask); // [RULE_19]
						end
						OP_ADDR_WATCH:
						begin
							// Registers are only read here, never written back
							nx.res_vld = 1'b0;
							nx.base = mon_addr & LINE_MASK; // [RULE_20] [RULE_22]
							nx.armed = 1'b1;
						end
						OP_WAIT_WATCHED_STORE:
						begin
							nx.res_vld = 1'b0;
							// Unarmed or already hit: no wait, so software never hangs
							if (r.armed && !hit)
							begin
								nx.done = 1'b0;
								nx.st = ST_SLEEP; // [RULE_21]
							end
						end
						default:
						begin
							nx.res_vld = 1'b0;
						end
					endcase
				end
			end
			ST_LOAD:
			begin
				if (mem_valid_i)
				begin
					nx.res = 128'(mem_data_i >> {r.off, 3'h0}); // [RULE_05]
					nx.res_vld = 1'b1;
					nx.done = 1'b1;
					nx.st = ST_IDLE;
				end
			end
			ST_SLEEP:
			begin
				if (hit)
				begin
					nx.done = 1'b1;
					nx.st = ST_IDLE; // [RULE_21]
				end
			end
			default:
			begin
				nx.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= nx;
	end

	assign res_o = r.res;
	assign res_valid_o = r.res_vld;
	assign res_dst_o = r.dst;
	assign simd_flags_o = r.sflg;
	assign simd_exc_o = r.sexc;
	assign int_res_o = r.ires;
	assign int_store_o = r.istore;
	assign fp_status_o = r.fstat;
	assign fp_exc_o = r.fexc;
	assign fp_pop_o = r.pop;
	assign ld_req_o = r.ldreq;
	assign ld_addr_o = r.ldaddr;
	assign ld_wide_o = r.ldwide;
	assign sleep_o = r.st == ST_SLEEP;
	assign done_o = r.done;

	property p_trunc_half;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_TRUNC_INT_STORE_POP && fp_stack_top_i == 64'hbff8_0000_0000_0000
		|=> int_res_o == 64'hffff_ffff_ffff_ffff && fp_pop_o && fp_status_o[1];
	endproperty
	a_trunc_half: assert property (p_trunc_half) else $error("Truncation wrong"); // [RULE_01]

	property p_trunc_word;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_TRUNC_INT_STORE_POP && int_width_i == IW_WORD
			&& fp_stack_top_i == 64'h40e0_0000_0000_0000
		|=> fp_status_o[0] && int_res_o[15:0] == 16'h8000;
	endproperty
	a_trunc_word: assert property (p_trunc_word) else $error("Word range wrong"); // [RULE_02]

	property p_trunc_unmask;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_TRUNC_INT_STORE_POP && !fp_control_word_i[FPCTL_IM]
			&& fp_stack_top_i == 64'h7ff8_0000_0000_0000
		|=> fp_exc_o && !fp_pop_o && !int_store_o;
	endproperty
	a_trunc_unmask: assert property (p_trunc_unmask) else $error("Unmask ignored"); // [RULE_03]

	property p_ld_aligned;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_SPLIT_AVOID_LOAD && addr_i[3:0] == 4'h0
		|-> ##1 ld_req_o && !ld_wide_o && ld_addr_o == $past(addr_i);
	endproperty
	a_ld_aligned: assert property (p_ld_aligned) else $error("Aligned fetch wrong"); // [RULE_04]

	property p_ld_wide;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_SPLIT_AVOID_LOAD && addr_i[3:0] != 4'h0
		|=> ld_req_o && ld_wide_o && ld_addr_o == {$past(addr_i[63:4]), 4'h0};
	endproperty
	a_ld_wide: assert property (p_ld_wide) else $error("Block fetch wrong"); // [RULE_05]

	property p_dup_odd;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_DUP_ODD
		|=> res_valid_o && res_o == {{2{$past(b_i[127:96])}}, {2{$past(b_i[63:32])}}};
	endproperty
	a_dup_odd: assert property (p_dup_odd) else $error("Odd duplicate wrong"); // [RULE_06]

	property p_dup_even;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_DUP_EVEN
		|=> res_valid_o && res_o == {{2{$past(b_i[95:64])}}, {2{$past(b_i[31:0])}}};
	endproperty
	a_dup_even: assert property (p_dup_even) else $error("Even duplicate wrong"); // [RULE_07]

	property p_dup_quad;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_DUP_QUAD |=> res_valid_o && res_o == {2{$past(b_i[63:0])}};
	endproperty
	a_dup_quad: assert property (p_dup_quad) else $error("Quad duplicate wrong"); // [RULE_08]

	property p_addsub;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_ADDSUB_SINGLE && a_i == {4{32'h3f80_0000}} && b_i == a_i
			&& rm == RM_NEAR
		|=> res_o == {32'h4000_0000, 32'h0, 32'h4000_0000, 32'h0};
	endproperty
	a_addsub: assert property (p_addsub) else $error("Add-subtract wrong"); // [RULE_09]

	property p_ext_idx;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		issue && op_i == OP_DUP_QUAD
		|=> res_dst_o[3] == $past(mode64_i && reg_extension_prefix_i
			&& reg_extension_index_bit_i);
	endproperty
	a_ext_idx: assert property (p_ext_idx) else $error("Register extension wrong"); // [RULE_15]

	property p_wake;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		sleep_o |=> (op_ready_o == $past(hit)) && (done_o == $past(hit))
			&& (sleep_o != $past(hit));
	endproperty
	a_wake: assert property (p_wake) else $error("Wait wake wrong"); // [RULE_21]
endmodule // sdahu_unit
`default_nettype wire

// ---- tb_simd_dup_addsub_horizontal_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_simd_dup_addsub_horizontal_unit
	import sdahu_pkg::*;
;
	localparam logic [31:0] S1 = 32'h3f80_0000;
	localparam logic [31:0] S2 = 32'h4000_0000;
	localparam logic [31:0] S3 = 32'h4040_0000;
	localparam logic [31:0] S4 = 32'h4080_0000;
	localparam logic [31:0] SM1 = 32'hbf80_0000;
	localparam logic [31:0] ST = 32'h3080_0000;
	localparam logic [63:0] D1 = 64'h3ff0_0000_0000_0000;
	localparam logic [63:0] D2 = 64'h4000_0000_0000_0000;
	localparam logic [63:0] D4 = 64'h4010_0000_0000_0000;
	logic clk, rst_n, vld, rdy, m64, rp, rr, rw, mv, sv, swb;
	logic rv, sexc, istr, fexc, pop, ldr, ldw, slp, done;
	sdahu_op_e op;
	logic [127:0] a, b, res;
	logic [255:0] pat, md;
	logic [63:0] ftop, addr, gaddr, saddr, ires, ldaddr;
	logic [31:0] csr;
	logic [15:0] cw;
	logic [2:0] idx;
	logic [1:0] iw, fst;
	logic [3:0] dst;
	logic [5:0] flg;
	int fails, num_checks;

	// Released data lines show the inverse, not a stale copy
	assign md = mv ? pat : ~pat;

	sdahu_unit sdahu_unit_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .op_valid_i(vld), .op_i(op), .op_ready_o(rdy),
		.a_i(a), .b_i(b), .reg_idx_i(idx), .mode64_i(m64), .reg_extension_prefix_i(rp),
		.reg_extension_index_bit_i(rr), .reg_extension_width_bit_i(rw),
		.simd_fp_ctrl_status_i(csr), .fp_control_word_i(cw),
		.fp_stack_top_i(ftop), .int_width_i(iw), .addr_i(addr), .gpr_addr_i(gaddr),
		.mem_data_i(md), .mem_valid_i(mv), .store_valid_i(sv), .store_wb_i(swb),
		.store_addr_i(saddr), .res_o(res), .res_valid_o(rv), .res_dst_o(dst),
		.simd_flags_o(flg), .simd_exc_o(sexc), .int_res_o(ires), .int_store_o(istr),
		.fp_status_o(fst), .fp_exc_o(fexc), .fp_pop_o(pop), .ld_req_o(ldr),
		.ld_addr_o(ldaddr), .ld_wide_o(ldw), .sleep_o(slp), .done_o(done)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Returns half a cycle after the take edge, where single-cycle pulses stand
	task automatic issue(input sdahu_op_e o);
		@(negedge clk);
		op = o;
		vld = 1'b1;
		@(negedge clk);
		vld = 1'b0;
	endtask

	task automatic run(input sdahu_op_e o, input logic [127:0] x, input logic [127:0] y);
		a = x;
		b = y;
		issue(o);
	endtask

	task automatic store(input logic [63:0] ad, input logic wb);
		@(negedge clk);
		sv = 1'b1;
		swb = wb;
		saddr = ad;
		@(negedge clk);
		sv = 1'b0;
	endtask

	task automatic t_dup;
		b = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
		m64 = 1'b1;
		rp = 1'b1;
		rr = 1'b1;
		rw = 1'b1;
		issue(OP_DUP_ODD);
		chk(res, 128'h4444_4444_4444_4444_2222_2222_2222_2222);
		chk({rv, done, dst}, 6'h3b);
		m64 = 1'b0;
		issue(OP_DUP_EVEN);
		chk(res, 128'h3333_3333_3333_3333_1111_1111_1111_1111);
		chk({rv, done, dst}, 6'h33);
		m64 = 1'b1;
		rp = 1'b0;
		issue(OP_DUP_QUAD);
		chk(res, {2{b[63:0]}});
		chk(dst, 4'h3);
	endtask

	task automatic t_arith;
		run(OP_ADDSUB_SINGLE, {4{S1}}, {4{S2}});
		chk(res, {S3, SM1, S3, SM1});
		chk({sexc, flg}, 7'h00);
		run(OP_ADDSUB_SINGLE, {4{S1}}, {4{S1}});
		chk(res, {S2, 32'h0, S2, 32'h0});
		run(OP_ADDSUB_DOUBLE, {2{D1}}, {2{D2}});
		chk(res, {64'h4008_0000_0000_0000, 64'hbff0_0000_0000_0000});
		run(OP_PAIR_ADD_SINGLE, {S4, S1, S2, S1}, {4{S2}});
		chk(res, {S4, S4, 32'h40a0_0000, S3});
		run(OP_PAIR_SUB_SINGLE, {S4, S1, S2, S1}, {4{S2}});
		chk(res, {64'h0, 32'hc040_0000, SM1});
		run(OP_PAIR_ADD_DOUBLE, {D4, D1}, {2{D2}});
		chk(res, {D4, 64'h4014_0000_0000_0000});
		run(OP_PAIR_SUB_DOUBLE, {D4, D1}, {2{D2}});
		chk(res, {64'h0, 64'hc008_0000_0000_0000});
		// Tiny addend exposes the up, down and nearest rounding directions
		csr = 32'h0000_5f80;
		run(OP_ADDSUB_SINGLE, {4{S1}}, {4{ST}});
		chk(res, {2{32'h3f80_0001, S1}});
		chk({sexc, flg}, 7'h20);
		csr = 32'h0000_3f80;
		run(OP_ADDSUB_SINGLE, {4{S1}}, {4{ST}});
		chk(res, {2{S1, 32'h3f7f_ffff}});
		csr = 32'h0000_0f80;
		run(OP_ADDSUB_SINGLE, {4{S1}}, {4{ST}});
		chk(res, {4{S1}});
		chk({sexc, flg}, 7'h60);
		csr = 32'h0000_1f80;
	endtask

	task automatic t_trunc;
		logic [63:0] tin [3];
		logic [63:0] tex [3];
		logic [1:0] tst [3];
		tin = '{64'hc006_0000_0000_0000, 64'h40f0_0008_0000_0000, 64'h4200_0000_0000_0000};
		tex = '{64'hffff_ffff_ffff_fffe, 64'h0000_0000_0001_0000, 64'h0000_0002_0000_0000};
		tst = '{2'h2, 2'h2, 2'h0};
		// Rounding field set to down: truncation must still win
		cw = 16'h077f;
		for (int i = 0; i < 3; i++)
		begin
			iw = i[1:0];
			ftop = tin[i];
			issue(OP_TRUNC_INT_STORE_POP);
			chk(ires, tex[i]);
			chk({istr, pop, done, fst}, {3'h7, tst[i]});
		end
		// Minus one and a half goes toward zero, not down
		ftop = 64'hbff8_0000_0000_0000;
		issue(OP_TRUNC_INT_STORE_POP);
		chk({ires, fst}, {64'hffff_ffff_ffff_ffff, 2'h2});
		iw = 2'h0;
		ftop = 64'h40e0_0000_0000_0000;
		issue(OP_TRUNC_INT_STORE_POP);
		chk({ires[15:0], istr, fst}, {16'h8000, 1'b1, 2'h1});
		cw = 16'h077e;
		ftop = tin[1];
		issue(OP_TRUNC_INT_STORE_POP);
		chk({fexc, istr, pop, fst[0]}, 4'h9);
		ftop = 64'h7ff8_0000_0000_0000;
		issue(OP_TRUNC_INT_STORE_POP);
		chk({fexc, istr, pop, fst}, 5'h11);
		cw = 16'h075f;
		ftop = tin[0];
		issue(OP_TRUNC_INT_STORE_POP);
		chk(fexc, 1'b1);
	endtask

	task automatic t_load;
		logic [63:0] ads [2];
		logic [127:0] e;
		ads = '{64'h1000, 64'h100f};
		for (int k = 0; k < 2; k++)
		begin
			addr = ads[k];
			issue(OP_SPLIT_AVOID_LOAD);
			chk({ldr, ldw, rdy}, {1'b1, k[0], 1'b0});
			chk(ldaddr, 64'h1000);
			// Slow memory on the second pass
			repeat (2 * k) @(negedge clk);
			mv = 1'b1;
			@(negedge clk);
			mv = 1'b0;
			for (int i = 0; i < 16; i++)
				e[8*i+:8] = 8'(int'(ads[k][3:0]) + i);
			chk(res, e);
			chk({rv, done, rdy}, 3'h7);
		end
	endtask

	task automatic t_watch;
		m64 = 1'b0;
		gaddr = 64'h1_0000_2040;
		issue(OP_ADDR_WATCH);
		chk(done, 1'b1);
		issue(OP_WAIT_WATCHED_STORE);
		chk({slp, rdy}, 2'h2);
		store(64'h2040, 1'b0);
		store(64'h2080, 1'b1);
		chk(slp, 1'b1);
		store(64'h207f, 1'b1);
		chk({slp, done, rdy}, 3'h3);
		issue(OP_WAIT_WATCHED_STORE);
		chk({slp, done}, 2'h1);
		m64 = 1'b1;
		rp = 1'b1;
		rw = 1'b1;
		issue(OP_ADDR_WATCH);
		issue(OP_WAIT_WATCHED_STORE);
		store(64'h2040, 1'b1);
		chk(slp, 1'b1);
		store(64'h1_0000_2040, 1'b1);
		chk({slp, done}, 2'h1);
	endtask

	task print_verdict;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		#50000;
		fails++;
		print_verdict;
	end

	initial
	begin
		fails = 0;
		num_checks = 0;
		rst_n = 1'b0;
		{vld, m64, rp, rr, rw, mv, sv, swb} = 8'h00;
		op = OP_DUP_ODD;
		a = '0;
		b = '0;
		idx = 3'h3;
		csr = 32'h0000_1f80;
		cw = 16'h037f;
		ftop = '0;
		iw = 2'h0;
		addr = '0;
		gaddr = '0;
		saddr = '0;
		for (int j = 0; j < 32; j++)
			pat[8*j+:8] = 8'(j);
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		t_dup;
		t_arith;
		t_trunc;
		t_load;
		t_watch;
		print_verdict;
	end
endmodule // tb_simd_dup_addsub_horizontal_unit
`default_nettype wire
